// ---- design/uhor_pkg.sv ----
// package: constants and carriers for the host controller operational registers
// Notes on behaviour
// R01: revision low byte reports implemented revision
// R02: suspended state moves to resume on resume
// R03: periodic work allowed only while enabled
// R04: routing bit picks normal pin or management
// R05: wakeup connected reads zero, enable ignored
// R06: reset bit self-clears when reset completes
// R07: list-filled bits cleared at list head start
// R08: ownership request sets ownership change flag
// R09: ownership change flag set on request
// R10: overrun counter counts overruns, wraps to zero
// R11: root hub change sets hub change flag
// R12: frame number msb toggle sets overflow
// R13: unrecoverable error flag reads zero always
// R14: resume signaling sets resume detected flag
// R15: start of frame sets frame flag
// R16: writeback flag set after done head written
// R17: master enable gates every interrupt source
// R18: disable master bit clears master enable
// R19: comm area base 256-byte aligned, low byte reserved
// R20: periodic descriptor 16-byte aligned, low nibble reserved
// R21: status write-one-clear, enable set, disable clear
// R22: interrupt asserted when master, flag, enable align
package uhor_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_REVISION  = 8'h00;
  localparam logic [7:0] OFS_CONTROL   = 8'h04;
  localparam logic [7:0] OFS_CMDSTAT   = 8'h08;
  localparam logic [7:0] OFS_INTFLAGS  = 8'h0c;
  localparam logic [7:0] OFS_INTENSET  = 8'h10;
  localparam logic [7:0] OFS_INTENCLR  = 8'h14;
  localparam logic [7:0] OFS_COMMAREA  = 8'h18;
  localparam logic [7:0] OFS_PERIODCUR = 8'h1c;

  // ==========================================================
  // control field positions
  localparam int CTL_RATIO_LO = 0;
  localparam int CTL_PERIODIC = 2;
  localparam int CTL_ISO_DIS  = 3;
  localparam int CTL_CTRL_EN  = 4;
  localparam int CTL_BULK_EN  = 5;
  localparam int CTL_STATE_LO = 6;
  localparam int CTL_ROUTE    = 8;
  localparam int CTL_WAKE_CON = 9;
  localparam int CTL_WAKE_EN  = 10;

  // command and status field positions
  localparam int CS_RESET   = 0;
  localparam int CS_CTRL_F  = 1;
  localparam int CS_BULK_F  = 2;
  localparam int CS_OWN_REQ = 3;
  localparam int CS_OVR_LO  = 16;

  // interrupt flag positions, shared by status, set and clear
  localparam int NUM_SRC = 7;
  localparam int INT_OVERRUN = 0;
  localparam int INT_WBDONE  = 1;
  localparam int INT_SOF     = 2;
  localparam int INT_RESUME  = 3;
  localparam int INT_FNOVF   = 5;
  localparam int INT_RHCHG   = 6;
  localparam int INT_OWNCHG  = 30;
  localparam int INT_MASTER  = 31;
  localparam int INT_POS [NUM_SRC] = '{0, 1, 2, 3, 5, 6, 30};

  // ==========================================================
  // pointer alignment masks
  localparam logic [31:0] COMM_AREA_MASK = 32'hffffff00;
  localparam logic [31:0] PERIOD_MASK    = 32'hfffffff0;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // revision byte; value arbitrary
  localparam logic [7:0] REVISION_CODE = 8'h01;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SWRST_TIME_NS  = 10000;
  localparam int SWRST_CYCLES   =
    (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWRST_CNT_W    = 10;

  // ==========================================================
  // functional state encodings
  typedef enum logic [1:0] {
    UHOR_FS_RESET   = 2'b00,
    UHOR_FS_RESUME  = 2'b01,
    UHOR_FS_OPER    = 2'b10,
    UHOR_FS_SUSPEND = 2'b11
  } uhor_fs_e;

  // soft reset sequencer states
  typedef enum logic [1:0] {
    UHOR_SR_IDLE = 2'b01,
    UHOR_SR_BUSY = 2'b10
  } uhor_sr_e;

  // ==========================================================
  // register access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } uhor_req_s;

  // events from the list processor, frame logic and root hub
  typedef struct packed {
    logic        sched_overrun;
    logic        writeback_done;
    logic        sof;
    logic        resume_seen;
    logic        rh_change;
    logic        frame_msb;
    logic        ctrl_head_start;
    logic        bulk_head_start;
    logic        ctrl_fill_set;
    logic        bulk_fill_set;
    logic        period_load;
    logic [31:0] period_ptr;
  } uhor_evt_s;

endpackage : uhor_pkg

// ---- design/uhor_flag_cell.sv ----
// sticky status flag whose set wins over its clear
`timescale 1ns/100ps
`default_nettype none
module uhor_flag_cell
  import uhor_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic set_i,
  input  wire logic clr_i,
  output var  logic flag_o
);

  logic flag_r;
  logic flag_nxt;

  // ==========================================================
  // next value
  // same-cycle event must not be lost under a clear
  assign flag_nxt = set_i | (flag_r & ~clr_i);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

endmodule : uhor_flag_cell
`default_nettype wire

// ---- design/uhor_regs.sv ----
// operational register bank of the usb host controller
`timescale 1ns/100ps
`default_nettype none
module uhor_regs
  import uhor_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire uhor_req_s   req_i,
  input  wire uhor_evt_s   evt_i,
  output var  logic        ack_o,
  output var  logic [31:0] rdata_o,
  output var  logic        irq_normal_o,
  output var  logic        irq_mgmt_o,
  output var  logic        periodic_ok_o,
  output var  logic        ctrl_list_en_o,
  output var  logic        bulk_list_en_o,
  output var  logic        iso_disable_o,
  output var  logic [1:0]  ctrl_bulk_ratio_o,
  output var  logic [1:0]  func_state_o,
  output var  logic        ctrl_filled_o,
  output var  logic        bulk_filled_o,
  output var  logic        soft_reset_o,
  output var  logic [31:0] comm_area_o,
  output var  logic [31:0] period_ptr_o
);

  // ==========================================================
  // storage
  logic [1:0]  ratio_r;
  logic        periodic_r;
  logic        iso_dis_r;
  logic        ctrl_en_r;
  logic        bulk_en_r;
  uhor_fs_e    fstate_r;
  logic        route_r;
  logic        wake_en_r;
  logic        ctrl_f_r;
  logic        bulk_f_r;
  logic        own_req_r;
  logic [1:0]  ovr_cnt_r;
  logic [NUM_SRC-1:0] int_en_r;
  logic        master_r;
  logic [31:0] comm_r;
  logic [31:0] period_r;
  logic        frame_msb_r;
  uhor_sr_e    sr_state_r;
  logic [SWRST_CNT_W-1:0] sr_cnt_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        irq_normal_r;
  logic        irq_mgmt_r;
  logic        periodic_ok_r;

  // next values
  logic [31:0] ctl_nxt;
  logic [31:0] comm_nxt;
  logic [31:0] period_nxt;
  uhor_sr_e    sr_state_nxt;
  logic [SWRST_CNT_W-1:0] sr_cnt_nxt;

  // ==========================================================
  // access decode
  logic [31:0] bmask;
  logic        wr;
  logic        rd;
  logic        wr_ctl;
  logic        wr_cs;
  logic        wr_flags;
  logic        wr_enset;
  logic        wr_enclr;
  logic        wr_comm;
  logic        wr_period;
  logic [31:0] wbits;
  logic        sr_busy;

  assign bmask = {{8{req_i.be[3]}}, {8{req_i.be[2]}},
                  {8{req_i.be[1]}}, {8{req_i.be[0]}}};
  assign wr        = req_i.valid & req_i.write & ~sr_busy;
  assign rd        = req_i.valid & ~req_i.write;
  assign wbits     = req_i.wdata & bmask;
  assign wr_ctl    = wr & (req_i.addr == OFS_CONTROL);
  assign wr_cs     = wr & (req_i.addr == OFS_CMDSTAT);
  assign wr_flags  = wr & (req_i.addr == OFS_INTFLAGS);
  assign wr_enset  = wr & (req_i.addr == OFS_INTENSET);
  assign wr_enclr  = wr & (req_i.addr == OFS_INTENCLR);
  assign wr_comm   = wr & (req_i.addr == OFS_COMMAREA);
  assign wr_period = wr & (req_i.addr == OFS_PERIODCUR);

  // ==========================================================
  // soft reset sequencer
  // writes are dropped while the reset runs so nothing half-applies
  logic sr_start;
  logic sr_done;

  assign sr_busy  = (sr_state_r == UHOR_SR_BUSY);
  assign sr_start = req_i.valid & req_i.write & ~sr_busy &
                    (req_i.addr == OFS_CMDSTAT) & wbits[CS_RESET];
  assign sr_done  = sr_busy &
                    (sr_cnt_r == SWRST_CNT_W'(SWRST_CYCLES - 1));

  always_comb begin
    sr_state_nxt = sr_state_r;
    sr_cnt_nxt   = sr_cnt_r;
    case (sr_state_r)
      UHOR_SR_IDLE: begin
        sr_cnt_nxt = '0;
        if (sr_start) begin
          sr_state_nxt = UHOR_SR_BUSY; // R06
        end
      end
      UHOR_SR_BUSY: begin
        sr_cnt_nxt = sr_cnt_r + SWRST_CNT_W'(1);
        if (sr_done) begin
          sr_state_nxt = UHOR_SR_IDLE; // R06
        end
      end
      default: begin
        sr_state_nxt = UHOR_SR_IDLE;
        sr_cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sr_state_r <= UHOR_SR_IDLE;
      sr_cnt_r   <= '0;
    end else begin
      sr_state_r <= sr_state_nxt;
      sr_cnt_r   <= sr_cnt_nxt;
    end
  end

  // ==========================================================
  // control register
  logic [31:0] ctl_cur;
  logic        resume_jump;

  assign ctl_cur = {21'h0, wake_en_r, 1'b0, route_r, fstate_r,
                    bulk_en_r, ctrl_en_r, iso_dis_r, periodic_r, ratio_r};
  // remote wakeup connected bit stays zero in every case
  assign resume_jump = (fstate_r == UHOR_FS_SUSPEND) &
                       evt_i.resume_seen; // R02

  always_comb begin
    ctl_nxt = ctl_cur;
    if (wr_ctl) begin
      ctl_nxt = (req_i.wdata & bmask) | (ctl_cur & ~bmask);
    end
    if (resume_jump) begin
      ctl_nxt[CTL_STATE_LO +: 2] = UHOR_FS_RESUME; // R02
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || sr_busy) begin
      ratio_r    <= 2'h0;
      periodic_r <= 1'b0;
      iso_dis_r  <= 1'b0;
      ctrl_en_r  <= 1'b0;
      bulk_en_r  <= 1'b0;
      fstate_r   <= UHOR_FS_RESET;
      route_r    <= 1'b0;
      wake_en_r  <= 1'b0;
    end else begin
      ratio_r    <= ctl_nxt[CTL_RATIO_LO +: 2];
      periodic_r <= ctl_nxt[CTL_PERIODIC];
      iso_dis_r  <= ctl_nxt[CTL_ISO_DIS];
      ctrl_en_r  <= ctl_nxt[CTL_CTRL_EN];
      bulk_en_r  <= ctl_nxt[CTL_BULK_EN];
      fstate_r   <= uhor_fs_e'(ctl_nxt[CTL_STATE_LO +: 2]);
      route_r    <= ctl_nxt[CTL_ROUTE];
      // accepted and stored, but steers nothing
      wake_en_r  <= ctl_nxt[CTL_WAKE_EN]; // R05
    end
  end

  // ==========================================================
  // command and status
  logic ctrl_f_nxt;
  logic bulk_f_nxt;
  logic own_req_nxt;
  logic own_rise;

  // a software or hardware set in the head-start cycle still wins
  assign ctrl_f_nxt = (wr_cs & wbits[CS_CTRL_F]) | evt_i.ctrl_fill_set |
                      (ctrl_f_r & ~evt_i.ctrl_head_start); // R07
  assign bulk_f_nxt = (wr_cs & wbits[CS_BULK_F]) | evt_i.bulk_fill_set |
                      (bulk_f_r & ~evt_i.bulk_head_start); // R07
  // software owns both edges of the request bit
  assign own_req_nxt = (wr_cs & req_i.be[0]) ?
                       req_i.wdata[CS_OWN_REQ] : own_req_r; // R08
  assign own_rise    = own_req_nxt & ~own_req_r; // R09

  always_ff @(posedge sys_clk) begin
    if (!rst_n || sr_busy) begin
      ctrl_f_r  <= 1'b0;
      bulk_f_r  <= 1'b0;
      own_req_r <= 1'b0;
    end else begin
      ctrl_f_r  <= ctrl_f_nxt;
      bulk_f_r  <= bulk_f_nxt;
      own_req_r <= own_req_nxt;
    end
  end

  // counts every overrun event, rolls over past all ones
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sr_busy) begin
      ovr_cnt_r <= 2'h0;
    end else if (evt_i.sched_overrun) begin
      ovr_cnt_r <= ovr_cnt_r + 2'h1; // R10
    end
  end

  // ==========================================================
  // interrupt flags
  logic [NUM_SRC-1:0] src_set;
  logic [NUM_SRC-1:0] src_clr;
  logic [NUM_SRC-1:0] flag;
  logic               fn_toggle;

  assign fn_toggle = evt_i.frame_msb ^ frame_msb_r; // R12

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_msb_r <= 1'b0;
    end else begin
      frame_msb_r <= evt_i.frame_msb;
    end
  end

  assign src_set[0] = evt_i.sched_overrun;
  assign src_set[1] = evt_i.writeback_done; // R16
  assign src_set[2] = evt_i.sof; // R15
  assign src_set[3] = evt_i.resume_seen; // R14
  assign src_set[4] = fn_toggle; // R12
  assign src_set[5] = evt_i.rh_change; // R11
  assign src_set[6] = own_rise; // R08 R09

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
      assign src_clr[gi] = sr_busy |
                           (wr_flags & wbits[INT_POS[gi]]); // R21
      uhor_flag_cell u_flag (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .set_i   (src_set[gi]),
        .clr_i   (src_clr[gi]),
        .flag_o  (flag[gi])
      );
    end
  endgenerate

  // ==========================================================
  // enable set and clear
  logic [NUM_SRC-1:0] en_set;
  logic [NUM_SRC-1:0] en_clr;

  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_en
      assign en_set[gi] = wr_enset & wbits[INT_POS[gi]]; // R21
      assign en_clr[gi] = wr_enclr & wbits[INT_POS[gi]]; // R21
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n || sr_busy) begin
      int_en_r <= '0;
      master_r <= 1'b0;
    end else begin
      int_en_r <= en_set | (int_en_r & ~en_clr);
      if (wr_enset && wbits[INT_MASTER]) begin
        master_r <= 1'b1;
      end else if (wr_enclr && wbits[INT_MASTER]) begin
        master_r <= 1'b0; // R18
      end
    end
  end

  // ==========================================================
  // interrupt output
  logic irq_any;

  assign irq_any = master_r & (|(flag & int_en_r)); // R17 R22

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_normal_r <= 1'b0;
      irq_mgmt_r   <= 1'b0;
    end else begin
      irq_normal_r <= irq_any & ~route_r; // R04
      irq_mgmt_r   <= irq_any & route_r; // R04
    end
  end

  // ==========================================================
  // pointer registers
  // low bits forced to zero on every load, so reads show them clear
  assign comm_nxt = wr_comm ?
    (((req_i.wdata & bmask) | (comm_r & ~bmask)) & COMM_AREA_MASK) :
    comm_r; // R19

  // the list processor overrides a same-cycle software write
  assign period_nxt = evt_i.period_load ?
    (evt_i.period_ptr & PERIOD_MASK) :
    wr_period ?
    (((req_i.wdata & bmask) | (period_r & ~bmask)) & PERIOD_MASK) :
    period_r; // R20

  always_ff @(posedge sys_clk) begin
    if (!rst_n || sr_busy) begin
      comm_r   <= RST_WORD;
      period_r <= RST_WORD;
    end else begin
      comm_r   <= comm_nxt;
      period_r <= period_nxt;
    end
  end

  // ==========================================================
  // periodic work gate
  // list processor samples this before any periodic transfer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      periodic_ok_r <= 1'b0;
    end else begin
      periodic_ok_r <= periodic_r & ~sr_busy; // R03
    end
  end

  // ==========================================================
  // read data
  logic [31:0] rd_rev;
  logic [31:0] rd_cs;
  logic [31:0] rd_flags;
  logic [31:0] rd_en;
  logic [31:0] rd_mux;

  assign rd_rev = {24'h0, REVISION_CODE}; // R01
  assign rd_cs  = {14'h0, ovr_cnt_r, 12'h0, own_req_r,
                   bulk_f_r, ctrl_f_r, sr_busy}; // R06

  // unrecoverable error bit is tied to zero
  assign rd_flags = {1'b0, flag[6], 23'h0, flag[5], flag[4],
                     1'b0, flag[3], flag[2], flag[1], flag[0]}; // R13
  assign rd_en    = {master_r, int_en_r[6], 23'h0, int_en_r[5],
                     int_en_r[4], 1'b0, int_en_r[3:0]};

  assign rd_mux =
    (req_i.addr == OFS_REVISION)  ? rd_rev   :
    (req_i.addr == OFS_CONTROL)   ? ctl_cur  : // R05
    (req_i.addr == OFS_CMDSTAT)   ? rd_cs    :
    (req_i.addr == OFS_INTFLAGS)  ? rd_flags :
    (req_i.addr == OFS_INTENSET)  ? rd_en    :
    (req_i.addr == OFS_INTENCLR)  ? rd_en    :
    (req_i.addr == OFS_COMMAREA)  ? comm_r   :
    (req_i.addr == OFS_PERIODCUR) ? period_r :
    32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= req_i.valid;
      rdata_r <= rd ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================
  // outputs
  assign ack_o             = ack_r;
  assign rdata_o           = rdata_r;
  assign irq_normal_o      = irq_normal_r;
  assign irq_mgmt_o        = irq_mgmt_r;
  assign periodic_ok_o     = periodic_ok_r;
  assign ctrl_list_en_o    = ctrl_en_r;
  assign bulk_list_en_o    = bulk_en_r;
  assign iso_disable_o     = iso_dis_r;
  assign ctrl_bulk_ratio_o = ratio_r;
  assign func_state_o      = fstate_r;
  assign ctrl_filled_o     = ctrl_f_r;
  assign bulk_filled_o     = bulk_f_r;
  assign soft_reset_o      = sr_state_r[1];
  assign comm_area_o       = comm_r;
  assign period_ptr_o      = period_r;

endmodule : uhor_regs
`default_nettype wire

// ---- testbench/uhor_regs_asserts.sv ----
// checker: port-level assertions for the operational register bank
`timescale 1ns/100ps
`default_nettype none
module uhor_regs_chk
  import uhor_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire uhor_req_s   req_i,
  input wire uhor_evt_s   evt_i,
  input wire logic [31:0] rdata_o,
  input wire logic        irq_normal_o,
  input wire logic        irq_mgmt_o,
  input wire logic        periodic_ok_o,
  input wire logic [1:0]  func_state_o,
  input wire logic        ctrl_filled_o,
  input wire logic        soft_reset_o,
  input wire logic [31:0] comm_area_o,
  input wire logic [31:0] period_ptr_o
);
  // ==========================================================
  // helpers
  logic [SWRST_CNT_W-1:0] cnt_r;
  wire rd_w = req_i.valid & ~req_i.write;
  wire wcmd_w = req_i.valid & req_i.write & (req_i.addr == OFS_CMDSTAT);

  // soft reset length, too long for a repetition
  always_ff @(posedge sys_clk) begin
    if (!rst_n) cnt_r <= '0;
    else cnt_r <= soft_reset_o ? cnt_r + 1'b1 : '0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // properties
  property p_rev;
    rd_w && req_i.addr == OFS_REVISION |=> rdata_o == {24'h0, REVISION_CODE};
  endproperty
  a_rev: assert property (p_rev) else $error("revision word wrong");
  property p_wake;
    rd_w && req_i.addr == OFS_CONTROL |=> !rdata_o[CTL_WAKE_CON];
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup bit set");
  property p_unrec;
    rd_w && req_i.addr == OFS_INTFLAGS |=> !rdata_o[4];
  endproperty
  a_unrec: assert property (p_unrec) else $error("error flag set");
  property p_route;
    !(irq_normal_o && irq_mgmt_o);
  endproperty
  a_route: assert property (p_route) else $error("both irq pins");
  property p_resume;
    func_state_o == UHOR_FS_SUSPEND && evt_i.resume_seen
      |=> func_state_o == UHOR_FS_RESUME;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_periodic;
    soft_reset_o && $past(soft_reset_o) |-> !periodic_ok_o;
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic on");
  property p_rst_set;
    wcmd_w && req_i.be[0] && req_i.wdata[CS_RESET] |-> ##[1:2] soft_reset_o;
  endproperty
  a_rst_set: assert property (p_rst_set) else $error("reset not run");
  property p_rst_len;
    $fell(soft_reset_o) |-> cnt_r >= SWRST_CYCLES && cnt_r <= SWRST_CYCLES + 1;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length");
  property p_fill;
    evt_i.ctrl_head_start && !evt_i.ctrl_fill_set && !wcmd_w
      |=> !ctrl_filled_o;
  endproperty
  a_fill: assert property (p_fill) else $error("filled kept");
  property p_period;
    evt_i.period_load && !soft_reset_o
      |=> period_ptr_o == ($past(evt_i.period_ptr) & PERIOD_MASK);
  endproperty
  a_period: assert property (p_period) else $error("period ptr");
  property p_comm;
    comm_area_o[7:0] == 8'h00;
  endproperty
  a_comm: assert property (p_comm) else $error("comm low byte");

  c_resume: cover property (func_state_o == UHOR_FS_RESUME);
  c_mgmt: cover property (irq_mgmt_o);
  c_swrst: cover property ($fell(soft_reset_o));
endmodule : uhor_regs_chk

bind uhor_regs uhor_regs_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .req_i(req_i), .evt_i(evt_i), .rdata_o(rdata_o),
  .irq_normal_o(irq_normal_o), .irq_mgmt_o(irq_mgmt_o),
  .periodic_ok_o(periodic_ok_o), .func_state_o(func_state_o),
  .ctrl_filled_o(ctrl_filled_o), .soft_reset_o(soft_reset_o),
  .comm_area_o(comm_area_o), .period_ptr_o(period_ptr_o));
`default_nettype wire

// ---- testbench/uhor_host_model.sv ----
// host driver model: memory-mapped register accesses
`timescale 1ns/100ps
`default_nettype none
module uhor_host_model
  import uhor_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        ack_o,
  input  wire logic [31:0] rdata_o,
  output var  uhor_req_s   req_i
);
  initial req_i = '0;

  // ==========================================================
  // one access; released data inverted
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] v, output logic [31:0] q);
    @(posedge sys_clk);
    req_i <= '{valid: 1'b1, write: w, addr: a, be: 4'hf, wdata: v};
    @(posedge sys_clk);
    req_i <= '{valid: 1'b0, write: w, addr: a, be: 4'hf, wdata: ~v};
    @(posedge sys_clk);
    q = ack_o ? rdata_o : 'x;
    @(posedge sys_clk);
  endtask : acc

  // software starts the reset, hardware ends it
  task automatic start_reset;
    logic [31:0] q;
    acc(1'b1, OFS_CMDSTAT, 32'h00000001, q);
  endtask : start_reset

  // request bit is only ever cleared from this side
  task automatic own_release;
    logic [31:0] q;
    acc(1'b1, OFS_CMDSTAT, 32'h00000000, q);
  endtask : own_release
endmodule : uhor_host_model
`default_nettype wire

// ---- testbench/uhor_regs_tb.sv ----
// self-checking testbench for the operational register bank
`timescale 1ns/100ps
`default_nettype none
module uhor_regs_tb
  import uhor_pkg::*;
  ;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  uhor_evt_s   evt_i = '0;
  uhor_evt_s   pe;
  uhor_req_s   req_i;
  logic        ack_o, irq_normal_o, irq_mgmt_o, periodic_ok_o;
  logic        ctrl_filled_o, soft_reset_o, cl, bl, iso;
  logic [1:0]  func_state_o, ra;
  logic [31:0] rdata_o, comm_area_o, period_ptr_o, d;
  int          bad_count = 0;
  int          comparisons = 0;

  always #10 sys_clk = ~sys_clk;

  uhor_host_model host (.sys_clk(sys_clk), .ack_o(ack_o),
    .rdata_o(rdata_o), .req_i(req_i));

  uhor_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_i(req_i),
    .evt_i(evt_i), .ack_o(ack_o), .rdata_o(rdata_o),
    .irq_normal_o(irq_normal_o), .irq_mgmt_o(irq_mgmt_o),
    .periodic_ok_o(periodic_ok_o), .ctrl_list_en_o(cl), .bulk_list_en_o(bl),
    .iso_disable_o(iso), .ctrl_bulk_ratio_o(ra), .func_state_o(func_state_o),
    .ctrl_filled_o(ctrl_filled_o), .bulk_filled_o(),
    .soft_reset_o(soft_reset_o), .comm_area_o(comm_area_o),
    .period_ptr_o(period_ptr_o));

  // ==========================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    host.acc(1'b0, a, '0, d);
    chk(n, e, d);
  endtask : rc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.acc(1'b1, a, v, d);
  endtask : wr
  // frame msb is a level, so it survives the pulse
  task automatic ev(input uhor_evt_s e);
    uhor_evt_s z;
    @(posedge sys_clk);
    evt_i <= e;
    @(posedge sys_clk);
    z = '0;
    z.frame_msb = e.frame_msb;
    evt_i <= z;
    repeat (2) @(posedge sys_clk);
  endtask : ev

  // ==========================================================
  // scenarios
  task automatic t_resets;
    rc(OFS_REVISION, {24'h0, REVISION_CODE}, "revision");
    for (int i = 1; i < 9; i++) rc(8'(i * 4), 32'h0, "reset word");
  endtask : t_resets

  task automatic t_control;
    wr(OFS_CONTROL, 32'hffffffff);
    rc(OFS_CONTROL, 32'h000005ff, "control");
    chk("ctl outs", 32'h3f, {26'h0, periodic_ok_o, iso, bl, cl, ra});
    pe = '0;
    pe.resume_seen = 1'b1;
    ev(pe);
    chk("state", 32'h1, 32'(func_state_o));
    rc(OFS_INTFLAGS, 32'h00000008, "resume flag");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_INTFLAGS, 32'hffffffff);
  endtask : t_control

  task automatic t_irq;
    wr(OFS_INTENSET, 32'h00000004);
    pe = '0;
    pe.sof = 1'b1;
    ev(pe);
    chk("irq no master", 32'h0, 32'(irq_normal_o));
    wr(OFS_INTENSET, 32'h80000000);
    chk("irq normal", 32'h1, 32'(irq_normal_o));
    wr(OFS_CONTROL, 32'h00000100);
    chk("irq mgmt", 32'h1, 32'(irq_mgmt_o));
    chk("irq normal off", 32'h0, 32'(irq_normal_o));
    wr(OFS_INTENCLR, 32'h80000000);
    chk("irq master off", 32'h0, 32'(irq_mgmt_o));
    rc(OFS_INTENSET, 32'h00000004, "enables left");
    wr(OFS_INTENSET, 32'h80000000);
    wr(OFS_INTFLAGS, 32'h0);
    chk("irq kept", 32'h1, 32'(irq_mgmt_o));
    wr(OFS_INTFLAGS, 32'h00000004);
    chk("irq cleared", 32'h0, 32'(irq_mgmt_o));
    wr(OFS_INTENSET, 32'hffffffff);
    rc(OFS_INTENCLR, 32'hc000006f, "all enables");
    wr(OFS_INTENCLR, 32'hffffffff);
    rc(OFS_INTENSET, 32'h0, "none enabled");
    wr(OFS_CONTROL, 32'h0);
  endtask : t_irq

  task automatic t_events;
    pe = '0;
    pe.writeback_done = 1'b1;
    pe.rh_change = 1'b1;
    pe.frame_msb = 1'b1;
    ev(pe);
    rc(OFS_INTFLAGS, 32'h00000062, "event flags");
    wr(OFS_INTFLAGS, 32'hffffffff);
    rc(OFS_INTFLAGS, 32'h0, "flags cleared");
    pe = '0;
    ev(pe);
    rc(OFS_INTFLAGS, 32'h00000020, "overflow on fall");
    pe.sched_overrun = 1'b1;
    for (int i = 0; i < 5; i++) ev(pe);
    rc(OFS_CMDSTAT, 32'h00010000, "overrun wrap");
  endtask : t_events

  task automatic t_lists;
    pe = '0;
    pe.ctrl_fill_set = 1'b1;
    ev(pe);
    chk("ctrl filled", 32'h1, 32'(ctrl_filled_o));
    pe = '0;
    pe.ctrl_head_start = 1'b1;
    ev(pe);
    chk("ctrl cleared", 32'h0, 32'(ctrl_filled_o));
    pe = '0;
    pe.bulk_fill_set = 1'b1;
    ev(pe);
    rc(OFS_CMDSTAT, 32'h00010004, "bulk filled");
    pe = '0;
    pe.bulk_head_start = 1'b1;
    ev(pe);
    rc(OFS_CMDSTAT, 32'h00010000, "bulk cleared");
    wr(OFS_INTFLAGS, 32'hffffffff);
    wr(OFS_CMDSTAT, 32'h00000008);
    rc(OFS_INTFLAGS, 32'h40000000, "ownership");
    host.own_release();
    rc(OFS_CMDSTAT, 32'h00010000, "request gone");
    wr(OFS_COMMAREA, 32'hffffffff);
    rc(OFS_COMMAREA, COMM_AREA_MASK, "comm area");
    chk("comm out", COMM_AREA_MASK, comm_area_o);
    wr(OFS_PERIODCUR, 32'hffffffff);
    rc(OFS_PERIODCUR, PERIOD_MASK, "period ptr");
    pe = '0;
    pe.period_load = 1'b1;
    pe.period_ptr = 32'h12345678;
    ev(pe);
    chk("period out", 32'h12345670, period_ptr_o);
  endtask : t_lists

  task automatic t_softrst;
    int n;
    wr(OFS_CONTROL, 32'h00000004);
    host.start_reset();
    chk("reset busy", 32'h1, 32'(soft_reset_o));
    chk("periodic off", 32'h0, 32'(periodic_ok_o));
    wr(OFS_CONTROL, 32'h00000004);
    n = 0;
    // bounded poll, ~125 reads
    do begin
      host.acc(1'b0, OFS_CMDSTAT, '0, d);
      n++;
    end while (d[CS_RESET] === 1'b1 && n < 300);
    chk("reset done", 32'h0, d);
    rc(OFS_CONTROL, 32'h0, "control cleared");
    rc(OFS_PERIODCUR, 32'h0, "ptr cleared");
  endtask : t_softrst

  // ==========================================================
  // verdict
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    #200us;
    bad_count++;
    results();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_resets();
    t_control();
    t_irq();
    t_events();
    t_lists();
    t_softrst();
    results();
  end
endmodule : uhor_regs_tb
`default_nettype wire
